// >>> shared/dps_defines.svh
// constants shared by both ends of the synchronous dual-port ram port
// assumes inclusion by bare name from shared/ on the include path
//
// Functional notes
// RULE1 - all port inputs except output enable clocked
// RULE2 - deselect floats outputs after next rising edge
// RULE3 - strobe low loads external address every edge
// RULE4 - pipelined pin state set by previous controls
// RULE5 - host rewrites data after no-operation cycle
// RULE6 - array address: pins when strobe low, counter otherwise
// RULE7 - counter reset needs no idle cycle
// RULE8 - cross-port write visibility symmetric between ports
// RULE9 - read after skewed write valid after delay
// RULE10 - depth expansion: same address, chip selects pick
// RULE11 - clear, load, hold, increment in priority order
// RULE12 - pipelined data one cycle after flow-through
// RULE13 - counter works regardless of chip selects
// RULE14 - host asserts both chip selects to select
// RULE15 - counter width matches array depth
`ifndef DPS_DEFINES_SVH
`define DPS_DEFINES_SVH
`define DPS_ADDR_W 14
`define DPS_DATA_W 18
`define DPS_CLK_NS 20
`define DPS_SKEW_WINDOW_NS 9
`define DPS_WR_TO_RD_NS 30
`define DPS_FLOW_CLK_TO_DATA_NS 15
// longest times round down, never below one cycle
`define DPS_WR_TO_RD_CYC ((`DPS_WR_TO_RD_NS / `DPS_CLK_NS) < 1 ? 1 : (`DPS_WR_TO_RD_NS / `DPS_CLK_NS))
`define DPS_COUNT_CLEAR_VALUE 0
`endif

// >>> shared/dps_pkg.sv
// types shared by both ends of the dual-port ram port
// assumes dps_defines.svh is on the include path
`include "dps_defines.svh"
package dps_pkg;
	typedef logic [`DPS_ADDR_W-1:0] dps_addr_t;
	typedef logic [`DPS_DATA_W-1:0] dps_data_t;
	typedef enum logic [3:0] {
		DPS_CLEAR = 4'h1,
		DPS_LOAD = 4'h2,
		DPS_HOLD = 4'h4,
		DPS_INCR = 4'h8
	} dps_cnt_e;
endpackage

// >>> shared/dps_if.sv
// pin bundle of one port of the dual-port ram
// assumes the bench resolves the data bus from the two enables
`timescale 1ns/10ps
`default_nettype none
interface dps_if;
	import dps_pkg::*;
	logic select_low_active_n;
	logic select_high_active;
	logic addr_strobe_n;
	logic count_advance_n;
	logic count_clear_n;
	logic write_n;
	logic output_enable_n;
	logic upper_byte_n;
	logic lower_byte_n;
	dps_addr_t addr;
	dps_data_t host_dq;
	logic host_dq_oe;
	dps_data_t ram_dq;
	logic ram_dq_oe;
	modport ram (
		input select_low_active_n, select_high_active, addr_strobe_n, count_advance_n,
		input count_clear_n, write_n, output_enable_n, upper_byte_n, lower_byte_n,
		input addr, host_dq, host_dq_oe,
		output ram_dq, ram_dq_oe
	);
	modport host (
		output select_low_active_n, select_high_active, addr_strobe_n, count_advance_n,
		output count_clear_n, write_n, output_enable_n, upper_byte_n, lower_byte_n,
		output addr, host_dq, host_dq_oe,
		input ram_dq, ram_dq_oe
	);
endinterface
`default_nettype wire

// >>> hdl/dps_ram.sv
// device end: one port of the dual-port ram plus shared array, second port plain
// holds the address counter, the array and the flow or pipelined output stage
// assumes both ports run on mclk; host side behind dps_if.ram, second port at user side
// assumes clk_en high for normal running; output enable reaches the pin untimed
`timescale 1ns/10ps
`default_nettype none
`include "dps_defines.svh"
module dps_ram #(
	parameter int ADDR_W = `DPS_ADDR_W,
	parameter bit PIPELINED = 1'b0
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic clk_en,
	dps_if.ram p,
	input wire logic b_write,
	input wire logic [ADDR_W-1:0] b_addr,
	input wire dps_pkg::dps_data_t b_wdata,
	output dps_pkg::dps_data_t b_rdata
);
	import dps_pkg::*;
	localparam int DW = `DPS_DATA_W;
	localparam int HALF = DW / 2;
	localparam int DEPTH = 1 << ADDR_W;
	logic [DW-1:0] mem [0:DEPTH-1];
	logic [ADDR_W-1:0] counter;
	logic [ADDR_W-1:0] array_addr;
	dps_cnt_e cnt_op;
	logic selected;
	logic do_read;
	logic do_write;
	logic wr_clash;
	logic [DW-1:0] flow_data;
	logic flow_drive;
	logic [DW-1:0] pipe_data;
	logic pipe_drive;
	logic [DW-1:0] next_rd;
	logic [DW-1:0] next_wr;
	logic [DW-1:0] next_b_rd;

	// ************************************************
	// decode helpers
	// ************************************************
	// clear beats load beats hold beats increment
	function automatic dps_cnt_e f_count_op(
		input logic clear_n,
		input logic strobe_n,
		input logic advance_n
	);
		dps_cnt_e op;
		if (!clear_n) begin
			op = DPS_CLEAR; // RULE11
		end else if (!strobe_n) begin
			op = DPS_LOAD; // RULE3
		end else if (advance_n) begin
			op = DPS_HOLD; // RULE11
		end else begin
			op = DPS_INCR; // RULE11
		end
		return op;
	endfunction

	// counter wraps from the top address back to zero
	function automatic logic [ADDR_W-1:0] f_array_addr(
		input dps_cnt_e op,
		input logic [ADDR_W-1:0] ext,
		input logic [ADDR_W-1:0] count
	);
		logic [ADDR_W-1:0] addr;
		addr = count;
		unique case (op)
			DPS_CLEAR: addr = ADDR_W'(`DPS_COUNT_CLEAR_VALUE); // RULE7
			DPS_LOAD: addr = ext; // RULE6
			DPS_HOLD: addr = count; // RULE6
			DPS_INCR: addr = count + ADDR_W'(1); // RULE11
		endcase
		return addr;
	endfunction

	function automatic logic f_selected(
		input logic low_n,
		input logic high
	);
		return !low_n && high;
	endfunction

	// ************************************************
	// data helpers
	// ************************************************
	// read-modify-write keeps the lane whose enable is off
	function automatic logic [DW-1:0] f_lane_merge(
		input logic [DW-1:0] old_word,
		input logic [DW-1:0] new_word,
		input logic upper_n,
		input logic lower_n
	);
		logic [DW-1:0] word;
		word = old_word;
		if (!lower_n) begin
			word[HALF-1:0] = new_word[HALF-1:0];
		end
		if (!upper_n) begin
			word[DW-1:HALF] = new_word[DW-1:HALF];
		end
		return word;
	endfunction

	// output enable gates the drive at once, with no clock in between
	function automatic logic f_drive_on(
		input logic drive,
		input logic oe_n
	);
		return drive && !oe_n;
	endfunction

	// ************************************************
	// counter and address
	// ************************************************
	assign cnt_op = f_count_op(p.count_clear_n, p.addr_strobe_n, p.count_advance_n);
	// reset address is used in the same cycle, so no dead cycle
	assign array_addr = f_array_addr(cnt_op, p.addr, counter); // RULE7
	// counter ignores chip selects
	always_ff @(posedge mclk or posedge rst) begin // RULE13
		if (rst) begin
			counter <= '0;
		end else if (clk_en) begin
			counter <= array_addr; // RULE1 RULE15
		end
	end

	// ************************************************
	// array writes
	// ************************************************
	assign selected = f_selected(p.select_low_active_n, p.select_high_active);
	assign do_read = selected && p.write_n;
	assign do_write = selected && !p.write_n;
	assign next_rd = mem[array_addr];
	assign next_wr = f_lane_merge(next_rd, p.host_dq, p.upper_byte_n, p.lower_byte_n);
	// same word from both ports in one edge: the second port wins
	assign wr_clash = do_write && b_write && (array_addr == b_addr);
	// read-first on both ports gives the same visibility either way
	always_ff @(posedge mclk) begin // RULE8
		if (clk_en && do_write && !wr_clash) begin
			mem[array_addr] <= next_wr;
		end
		if (clk_en && b_write) begin
			mem[b_addr] <= b_wdata;
		end
	end

	// ************************************************
	// second port read
	// ************************************************
	assign next_b_rd = mem[b_addr];
	// same-edge collision: the other port sees the new word one cycle on
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			b_rdata <= '0;
		end else if (clk_en) begin
			b_rdata <= next_b_rd; // RULE9
		end
	end

	// ************************************************
	// output timing
	// ************************************************
	// flow-through: data and drive one edge after the controls
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			flow_data <= '0;
		end else if (clk_en) begin
			flow_data <= next_rd;
		end
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			flow_drive <= 1'b0;
		end else if (clk_en) begin
			flow_drive <= do_read; // RULE2
		end
	end
	// pipelined: one more stage, so the previous cycle decides the pins
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pipe_data <= '0;
		end else if (clk_en) begin
			pipe_data <= flow_data; // RULE12
		end
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pipe_drive <= 1'b0;
		end else if (clk_en) begin
			pipe_drive <= flow_drive; // RULE4
		end
	end

	// ************************************************
	// output pins
	// ************************************************
	// the parameter picks the tap, so no mux is left in the path
	if (PIPELINED) begin : g_pipe_out
		assign p.ram_dq = pipe_data;
		assign p.ram_dq_oe = f_drive_on(pipe_drive, p.output_enable_n);
	end else begin : g_flow_out
		assign p.ram_dq = flow_data;
		assign p.ram_dq_oe = f_drive_on(flow_drive, p.output_enable_n);
	end
endmodule
`default_nettype wire

// >>> hdl/dps_host.sv
// host end: issues one access per request onto a port of the ram
// assumes the ram runs on the same mclk; read data returned after a fixed latency
`timescale 1ns/10ps
`default_nettype none
`include "dps_defines.svh"
module dps_host #(
	parameter int ADDR_W = `DPS_ADDR_W,
	parameter bit PIPELINED = 1'b0
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic clk_en,
	dps_if.host p,
	input wire logic req,
	input wire logic req_write,
	input wire logic req_burst,
	input wire logic req_clear,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire dps_pkg::dps_data_t req_wdata,
	output logic rd_valid,
	output dps_pkg::dps_data_t rd_data
);
	import dps_pkg::*;
	localparam int LAT = PIPELINED ? 3 : 2;
	logic [LAT-1:0] rd_pipe;
	// ************************************************
	// pin drive, registered on mclk except byte enables tied low and output enable from host_dq_oe
	// ************************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			p.select_low_active_n <= 1'b1;
			p.select_high_active <= 1'b0;
			p.addr_strobe_n <= 1'b1;
			p.count_advance_n <= 1'b1;
			p.count_clear_n <= 1'b1;
			p.write_n <= 1'b1;
			p.addr <= '0;
			p.host_dq <= '0;
			p.host_dq_oe <= 1'b0;
		end else if (clk_en) begin
			p.select_low_active_n <= !req; // RULE14 RULE10
			p.select_high_active <= req; // RULE14
			p.addr_strobe_n <= !(req && !req_burst);
			p.count_advance_n <= !(req && req_burst);
			p.count_clear_n <= !(req && req_clear);
			p.write_n <= !(req && req_write); // RULE1
			p.addr <= req_addr;
			p.host_dq <= req_wdata;
			p.host_dq_oe <= req && req_write;
		end
	end
	assign p.output_enable_n = p.host_dq_oe;
	assign p.upper_byte_n = 1'b0;
	assign p.lower_byte_n = 1'b0;
	// ************************************************
	// read return
	// ************************************************
	// user must rewrite words touched around idle gaps
	always_ff @(posedge mclk or posedge rst) begin // RULE5
		if (rst) begin
			rd_pipe <= '0;
			rd_valid <= 1'b0;
			rd_data <= '0;
		end else if (clk_en) begin
			rd_pipe <= {rd_pipe[LAT-2:0], req && !req_write};
			rd_valid <= rd_pipe[LAT-1] && p.ram_dq_oe; // RULE9
			rd_data <= p.ram_dq;
		end
	end
endmodule
`default_nettype wire

// >>> verification/dps_checker.sv
// assertions on the pin bundle between the host end and the ram end
// assumes flow-through ram, one clock, rst async active high
`timescale 1ns/10ps
`default_nettype none
module dps_checker (
	input wire logic mclk,
	input wire logic rst,
	input wire logic select_low_active_n,
	input wire logic select_high_active,
	input wire logic write_n,
	input wire logic output_enable_n,
	input wire logic host_dq_oe,
	input wire logic ram_dq_oe
);
	// ****
	// pin relations
	// ****
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	logic sel;
	assign sel = !select_low_active_n && select_high_active;
	a_deselect_floats: assert property (!sel |=> !ram_dq_oe)
		else $error("ram drives after deselect");
	a_write_no_drive: assert property (!write_n |=> !ram_dq_oe)
		else $error("ram drives after write cycle");
	a_oe_async_off: assert property (output_enable_n |-> !ram_dq_oe)
		else $error("ram drives with output enable off");
	a_read_drives_next: assert property (sel && write_n ##1 !output_enable_n |-> ram_dq_oe)
		else $error("read cycle not driven next cycle");
	a_drive_has_cause: assert property ($rose(ram_dq_oe) |-> $past(sel && write_n))
		else $error("ram drive without previous read");
	a_no_bus_fight: assert property (!(host_dq_oe && ram_dq_oe))
		else $error("both ends drive data");
	a_select_pair: assert property (select_low_active_n == !select_high_active)
		else $error("selects not moved together");
	a_write_blocks_oe: assert property (!write_n |-> output_enable_n)
		else $error("output enable on during write");
	cover property (sel && write_n ##1 ram_dq_oe);
	cover property (sel && !write_n);
	cover property (!sel ##1 sel);
endmodule
`default_nettype wire

// >>> verification/dual_port_sync_sram_port_bench.sv
// self-checking bench: host end and ram end joined by the pin bundle
// assumes one 50 MHz clock, flow-through outputs
`timescale 1ns/10ps
`default_nettype none
module dual_port_sync_sram_port_bench;
	import dps_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	logic req = 1'b0;
	logic req_write = 1'b0;
	logic req_burst = 1'b0;
	logic req_clear = 1'b0;
	dps_addr_t req_addr = 14'h0000;
	dps_data_t req_wdata = 18'h00000;
	logic rd_valid;
	dps_data_t rd_data;
	logic b_write = 1'b0;
	dps_addr_t b_addr = 14'h0000;
	dps_data_t b_wdata = 18'h00000;
	dps_data_t b_rdata;
	int bad_count = 0;
	int tests_run = 0;
	always #10 mclk = ~mclk;
	dps_if bus_if();
	dps_ram u_dps_ram (.mclk(mclk), .rst(rst), .clk_en(clk_en), .p(bus_if), .b_write(b_write),
		.b_addr(b_addr), .b_wdata(b_wdata), .b_rdata(b_rdata));
	dps_host u_dps_host (.mclk(mclk), .rst(rst), .clk_en(clk_en), .p(bus_if), .req(req),
		.req_write(req_write), .req_burst(req_burst), .req_clear(req_clear),
		.req_addr(req_addr), .req_wdata(req_wdata), .rd_valid(rd_valid), .rd_data(rd_data));
	dps_checker u_dps_checker (.mclk(mclk), .rst(rst),
		.select_low_active_n(bus_if.select_low_active_n),
		.select_high_active(bus_if.select_high_active), .write_n(bus_if.write_n),
		.output_enable_n(bus_if.output_enable_n), .host_dq_oe(bus_if.host_dq_oe),
		.ram_dq_oe(bus_if.ram_dq_oe));
	// ****
	// shared tasks
	// ****
	task chk(input dps_data_t got, input dps_data_t exp);
		tests_run++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			bad_count++;
		end
	endtask
	task report_and_stop;
		$display("compares %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task b_wr(input dps_addr_t a, input dps_data_t d);
		@(posedge mclk);
		#1 b_write = 1'b1;
		b_addr = a;
		b_wdata = d;
		@(posedge mclk);
		#1 b_write = 1'b0;
	endtask
	task b_rd(input dps_addr_t a, input dps_data_t exp);
		@(posedge mclk);
		#1 b_addr = a;
		repeat (2) @(posedge mclk);
		#1 chk(b_rdata, exp);
	endtask
	// one request; reads wait for rd_valid under a bound
	task hop(input logic w, input logic bu, input logic cl, input dps_addr_t a,
		input dps_data_t d);
		int n;
		n = 0;
		@(posedge mclk);
		#1 req = 1'b1;
		req_write = w;
		req_burst = bu;
		req_clear = cl;
		req_addr = a;
		req_wdata = d;
		@(posedge mclk);
		#1 req = 1'b0;
		while (!w && rd_valid !== 1'b1 && n < 8) begin
			@(posedge mclk);
			#1 n++;
		end
		if (n == 8) begin
			bad_count++;
			report_and_stop();
		end
	endtask
	task hrd(input dps_addr_t a, input dps_data_t exp, input logic bu, input logic cl);
		hop(1'b0, bu, cl, a, 18'h00000);
		chk(rd_data, exp);
	endtask
	// ****
	// scenarios
	// ****
	task t_cross;
		b_wr(14'h0005, 18'h2A5A5);
		hrd(14'h0005, 18'h2A5A5, 1'b0, 1'b0);
		hop(1'b1, 1'b0, 1'b0, 14'h0006, 18'h15A5A);
		b_rd(14'h0006, 18'h15A5A);
		$display("test cross done");
	endtask
	task t_random;
		dps_addr_t tab [3] = '{14'h3FFF, 14'h0010, 14'h2000};
		foreach (tab[i]) b_wr(tab[i], {tab[i], 4'hC});
		foreach (tab[i]) hrd(tab[2-i], {tab[2-i], 4'hC}, 1'b0, 1'b0);
		$display("test random done");
	endtask
	// external address 2000 is ignored whenever the counter supplies it
	task t_counter;
		b_wr(14'h0000, 18'h00011);
		b_wr(14'h0001, 18'h00022);
		hrd(14'h3FFF, 18'h3FFFC, 1'b0, 1'b0);
		hrd(14'h2000, 18'h00011, 1'b1, 1'b0);
		hrd(14'h2000, 18'h00022, 1'b1, 1'b0);
		hrd(14'h2000, 18'h00011, 1'b0, 1'b1);
		repeat (3) @(posedge mclk);
		hrd(14'h2000, 18'h00022, 1'b1, 1'b0);
		hop(1'b1, 1'b0, 1'b1, 14'h0555, 18'h3ABCD);
		b_rd(14'h0000, 18'h3ABCD);
		$display("test counter done");
	endtask
	// a write held through frozen edges must not land
	task t_freeze;
		b_wr(14'h0007, 18'h11111);
		clk_en = 1'b0;
		b_wr(14'h0007, 18'h22222);
		clk_en = 1'b1;
		b_rd(14'h0007, 18'h11111);
		$display("test freeze done");
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		#1 rst = 1'b0;
		t_cross();
		t_random();
		t_counter();
		t_freeze();
		report_and_stop();
	end
endmodule
`default_nettype wire
